/* File: hw/dbsi_pkg.sv */
/*
  Constants for the two-word burst DDR SRAM device block: widths, array
  depth, burst lane layout, reset values and cycle counts.
  Assumes the core clock runs at 250 MHz and the link clocks are the
  controller's positive input clock, sampled on both of its edges.
*/
package dbsi_pkg;

  // Core clock and timing
  localparam int CLK_PERIOD_NS = 4;    // Core clock period, ns
  localparam int STOP_NS       = 30;   // Least link-clock stop that resets the loop, ns
  localparam int STOP_CYC      = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Link-side cycle counts
  localparam int LOCK_CYC = 2048;     // Stable link cycles before delay-loop lock
  localparam int CAL_CYC  = 1024;     // Link cycles between impedance updates
  localparam int CNT_W    = 12;       // Width of the link-side counters
  localparam int IDLE_W   = 4;        // Width of the core-side stop counter

  // Data path geometry
  localparam int WORD_W   = 18;       // One data word on the pins
  localparam int LANE_W   = 9;        // One byte lane (with parity bit)
  localparam int LANES    = 2;        // Byte lanes per word
  localparam int LINE_W   = 2 * WORD_W;  // Burst pair stored per location
  localparam int LINE_LN  = 2 * LANES;   // Lane enables per location
  localparam int ADDR_W   = 21;       // Burst address on the pins
  localparam int ARRAY_AW = 10;       // Array index bits actually stored

  // Reset values
  localparam logic [WORD_W-1:0]  WORD_RST = 18'h00000;
  localparam logic [LINE_W-1:0]  LINE_RST = 36'h000000000;
  localparam logic [ADDR_W-1:0]  ADDR_RST = 21'h000000;
  localparam logic [LANES-1:0]   MASK_RST = 2'h0;
  localparam logic [CNT_W-1:0]   CNT_RST  = 12'h000;
  localparam logic [IDLE_W-1:0]  IDLE_RST = 4'h0;

endpackage

/* File: hw/dbsi_sram.sv */
/*
  Device-side logic of a synchronous two-word burst SRAM with a DDR
  common-I/O link: command decode, write capture, posted write with read
  bypass, read pipeline of one or two cycles, echo clocks, valid flag,
  delay-loop lock and impedance update timing.
  Assumes the controller drives all link inputs synchronous to k_clk
  (rising edge for commands, both edges for data) and that the test
  environment resolves the shared data wires from dq_oe.
*/
// Functional notes
// - Accesses start on positive clock rise only
// - Read data two rises later, then next word
// - Started read bursts always complete fully
// - New read accepted on every positive rise
// - After last read, release bus next rise
// - Write command captures address into register
// - Capture two words, commit 36 bits
// - New write accepted on every positive rise
// - Idle after writes; inputs ignored until command
// - Active-low lane selects gate each word lane
// - Posted write committed at next write
// - Same-address read returns newest write data
// - Impedance update every 1024 link cycles
// - Two free-running echo clocks follow link clock
// - Valid flag rises half cycle before data
// - Loop disabled: one-cycle read latency
// - Loop resets when link clock stops 30 ns
// - Lock after 2048 stable link cycles
// - Powers up deselected, outputs released
`timescale 1ns/10ps
module dbsi_sram
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          k_clk,
  input  wire logic                          load_strobe_n,
  input  wire logic                          read_write_sel,
  input  wire logic [dbsi_pkg::ADDR_W-1:0]   addr,
  input  wire logic [dbsi_pkg::WORD_W-1:0]   dq_in,
  input  wire logic [dbsi_pkg::LANES-1:0]    byte_lane_write_select_n,
  input  wire logic                          delay_loop_disable_n,
  output logic      [dbsi_pkg::WORD_W-1:0]   dq_out,
  output logic                               dq_oe,
  output logic                               echo_clock,
  output logic                               echo_clock_n,
  output logic                               output_valid_flag,
  output logic                               impedance_update,
  output logic                               delay_loop_locked
);

  // Link-domain reset and pin synchronisers
  logic                          k_rst_s1_reg;      // First stage, read only by the second
  logic                          k_rst;             // Reset as seen by the link domain
  logic                          en_s1_reg;         // Loop enable, first stage
  logic                          en_s2_reg;         // Loop enable, usable
  logic                          lrst_s1_reg;       // Loop reset from core, first stage
  logic                          lrst_s2_reg;       // Loop reset from core, usable

  // Command stage
  logic                          rd_req1_reg;       // Read taken on the last rise
  logic [dbsi_pkg::ADDR_W-1:0]   rd_addr1_reg;      // Its address
  logic                          rd_req2_reg;       // Read one stage further on
  logic [dbsi_pkg::LINE_W-1:0]   rd_data2_reg;      // Its data, already merged
  logic                          wr_phase_reg;      // Word 0 of a write due now
  logic [dbsi_pkg::ADDR_W-1:0]   wr_addr_reg;       // Write address register

  // Write data capture and posted write
  logic                          pd_valid_reg;      // Pending burst being captured
  logic [dbsi_pkg::ADDR_W-1:0]   pd_addr_reg;
  logic [dbsi_pkg::WORD_W-1:0]   pd_w0_reg;
  logic [dbsi_pkg::LANES-1:0]    pd_m0_reg;
  logic [dbsi_pkg::WORD_W-1:0]   pd_w1_reg;         // Captured on the falling edge
  logic [dbsi_pkg::LANES-1:0]    pd_m1_reg;
  logic                          pw_valid_reg;      // Posted write held back
  logic [dbsi_pkg::ADDR_W-1:0]   pw_addr_reg;
  logic [dbsi_pkg::LINE_W-1:0]   pw_data_reg;
  logic [dbsi_pkg::LINE_LN-1:0]  pw_mask_reg;

  // Output side
  logic                          rise_tog_reg;      // Toggles on each rise
  logic                          fall_tog_reg;      // Copy of the rise toggle, taken on each fall
  logic [dbsi_pkg::WORD_W-1:0]   q_rise_reg;
  logic [dbsi_pkg::WORD_W-1:0]   q_hi_reg;          // Second word waiting for the fall
  logic [dbsi_pkg::WORD_W-1:0]   q_fall_reg;
  logic                          oe_rise_reg;
  logic                          oe_fall_reg;
  logic                          valid_reg;

  // Timers
  logic [dbsi_pkg::CNT_W-1:0]    cal_cnt_reg;
  logic                          cal_pulse_reg;
  logic [dbsi_pkg::CNT_W-1:0]    lock_cnt_reg;
  logic                          locked_reg;

  // Core-domain stop detector
  logic                          kt_s1_reg;         // Link toggle, first stage
  logic                          kt_s2_reg;
  logic                          kt_s3_reg;         // Delayed copy for change detect
  logic [dbsi_pkg::IDLE_W-1:0]   idle_cnt_reg;
  logic                          lrst_reg;          // Loop reset level, core domain

  // Array
  logic [dbsi_pkg::LINE_W-1:0]   mem [2**dbsi_pkg::ARRAY_AW];

  logic                          rd_cmd;
  logic                          wr_cmd;
  logic                          lat1;
  logic                          phase;
  logic [dbsi_pkg::LINE_W-1:0]   merged;
  logic [dbsi_pkg::LINE_W-1:0]   pd_line;
  logic [dbsi_pkg::LINE_LN-1:0]  pd_mask;

  // Replace the enabled lanes of base with those of data
  function automatic logic [dbsi_pkg::LINE_W-1:0] lane_merge(
    input logic [dbsi_pkg::LINE_W-1:0]  base,
    input logic [dbsi_pkg::LINE_W-1:0]  data,
    input logic [dbsi_pkg::LINE_LN-1:0] en
  );
    logic [dbsi_pkg::LINE_W-1:0] r;
    r = base;
    for (int i = 0; i < dbsi_pkg::LINE_LN; i++)
    begin
      if (en[i])
      begin
        r[i*dbsi_pkg::LANE_W +: dbsi_pkg::LANE_W] = data[i*dbsi_pkg::LANE_W +: dbsi_pkg::LANE_W];
      end
    end
    return r;
  endfunction

  // Command decode; a high strobe starts nothing
  assign rd_cmd  = !load_strobe_n && read_write_sel;
  assign wr_cmd  = !load_strobe_n && !read_write_sel;
  assign lat1    = !en_s2_reg;
  assign pd_line = {pd_w1_reg, pd_w0_reg};
  assign pd_mask = {pd_m1_reg, pd_m0_reg};

  // Newest data wins: pending burst over posted write over array
  always_comb
  begin
    merged = mem[rd_addr1_reg[dbsi_pkg::ARRAY_AW-1:0]];
    if (pw_valid_reg && pw_addr_reg == rd_addr1_reg)
    begin
      merged = lane_merge(merged, pw_data_reg, pw_mask_reg);
    end
    if (pd_valid_reg && pd_addr_reg == rd_addr1_reg)
    begin
      merged = lane_merge(merged, pd_line, pd_mask);
    end
  end

  // Reset and static pins brought into the link domain
  always_ff @(posedge k_clk)
  begin
    k_rst_s1_reg <= rst;
    k_rst        <= k_rst_s1_reg;
    en_s1_reg    <= delay_loop_disable_n;
    en_s2_reg    <= en_s1_reg;
    lrst_s1_reg  <= lrst_reg;
    lrst_s2_reg  <= lrst_s1_reg;
  end

  // Read pipeline; every taken read runs to the end whatever follows
  always_ff @(posedge k_clk)
  begin
    if (k_rst)
    begin
      rd_req1_reg  <= 1'b0;
      rd_addr1_reg <= dbsi_pkg::ADDR_RST;
      rd_req2_reg  <= 1'b0;
      rd_data2_reg <= dbsi_pkg::LINE_RST;
    end
    else
    begin
      rd_req1_reg  <= rd_cmd;
      rd_addr1_reg <= addr;
      rd_req2_reg  <= rd_req1_reg && !lat1;
      rd_data2_reg <= merged;
    end
  end

  // Write address register and word 0 capture with its lane selects
  always_ff @(posedge k_clk)
  begin
    if (k_rst)
    begin
      wr_phase_reg <= 1'b0;
      wr_addr_reg  <= dbsi_pkg::ADDR_RST;
      pd_valid_reg <= 1'b0;
      pd_addr_reg  <= dbsi_pkg::ADDR_RST;
      pd_w0_reg    <= dbsi_pkg::WORD_RST;
      pd_m0_reg    <= dbsi_pkg::MASK_RST;
    end
    else
    begin
      wr_phase_reg <= wr_cmd;
      if (wr_cmd)
      begin
        wr_addr_reg <= addr;
      end
      // Data pins are only looked at in a data phase, idle otherwise
      pd_valid_reg <= wr_phase_reg;
      if (wr_phase_reg)
      begin
        pd_addr_reg <= wr_addr_reg;
        pd_w0_reg   <= dq_in;
        pd_m0_reg   <= ~byte_lane_write_select_n;
      end
    end
  end

  // Word 1 arrives on the falling edge of the same cycle
  always_ff @(negedge k_clk)
  begin
    if (k_rst)
    begin
      pd_w1_reg <= dbsi_pkg::WORD_RST;
      pd_m1_reg <= dbsi_pkg::MASK_RST;
    end
    else if (pd_valid_reg)
    begin
      pd_w1_reg <= dq_in;
      pd_m1_reg <= ~byte_lane_write_select_n;
    end
  end

  // Posted write: the older one goes to the array when a new one lands
  always_ff @(posedge k_clk)
  begin
    if (k_rst)
    begin
      pw_valid_reg <= 1'b0;
      pw_addr_reg  <= dbsi_pkg::ADDR_RST;
      pw_data_reg  <= dbsi_pkg::LINE_RST;
      pw_mask_reg  <= 4'h0;
    end
    else if (pd_valid_reg)
    begin
      pw_valid_reg <= 1'b1;
      pw_addr_reg  <= pd_addr_reg;
      pw_data_reg  <= pd_line;
      pw_mask_reg  <= pd_mask;
    end
  end

  // Array commit; only lanes that were selected change
  always_ff @(posedge k_clk)
  begin
    if (!k_rst && pd_valid_reg && pw_valid_reg)
    begin
      mem[pw_addr_reg[dbsi_pkg::ARRAY_AW-1:0]] <=
        lane_merge(mem[pw_addr_reg[dbsi_pkg::ARRAY_AW-1:0]], pw_data_reg, pw_mask_reg);
    end
  end

  // Rising-edge output: word 0, drive enable, and word 1 held for the fall
  always_ff @(posedge k_clk)
  begin
    if (k_rst)
    begin
      rise_tog_reg <= 1'b0;
      q_rise_reg   <= dbsi_pkg::WORD_RST;
      q_hi_reg     <= dbsi_pkg::WORD_RST;
      oe_rise_reg  <= 1'b0;
    end
    else
    begin
      rise_tog_reg <= ~rise_tog_reg;
      if (lat1)
      begin
        oe_rise_reg <= rd_req1_reg;
        q_rise_reg  <= merged[dbsi_pkg::WORD_W-1:0];
        q_hi_reg    <= merged[dbsi_pkg::LINE_W-1:dbsi_pkg::WORD_W];
      end
      else
      begin
        // Released here once no burst is due, the rise after the last fall
        oe_rise_reg <= rd_req2_reg;
        q_rise_reg  <= rd_data2_reg[dbsi_pkg::WORD_W-1:0];
        q_hi_reg    <= rd_data2_reg[dbsi_pkg::LINE_W-1:dbsi_pkg::WORD_W];
      end
    end
  end

  // Falling-edge output: word 1 and the valid flag half a cycle early
  always_ff @(negedge k_clk)
  begin
    if (k_rst)
    begin
      fall_tog_reg <= 1'b0;
      q_fall_reg   <= dbsi_pkg::WORD_RST;
      oe_fall_reg  <= 1'b0;
      valid_reg    <= 1'b0;
    end
    else
    begin
      // Copying rather than toggling keeps the echo high after a rise, even
      // when the first fall out of reset comes before the first rise
      fall_tog_reg <= rise_tog_reg;
      q_fall_reg   <= q_hi_reg;
      oe_fall_reg  <= oe_rise_reg;
      valid_reg    <= lat1 ? rd_req1_reg : rd_req2_reg;
    end
  end

  // Phase is high from a rise to the next fall; one flop per edge keeps
  // every signal on one edge, at the cost of a mux after the flops
  assign phase             = rise_tog_reg ^ fall_tog_reg;
  assign echo_clock        = phase;
  assign echo_clock_n      = ~phase;
  assign dq_out            = phase ? q_rise_reg : q_fall_reg;
  assign dq_oe             = phase ? oe_rise_reg : oe_fall_reg;
  assign output_valid_flag = valid_reg;
  assign impedance_update  = cal_pulse_reg;
  assign delay_loop_locked = locked_reg;

  // Impedance update tick, one pulse per period of link cycles
  always_ff @(posedge k_clk)
  begin
    if (k_rst)
    begin
      cal_cnt_reg   <= dbsi_pkg::CNT_RST;
      cal_pulse_reg <= 1'b0;
    end
    else
    begin
      cal_pulse_reg <= (cal_cnt_reg == 12'(dbsi_pkg::CAL_CYC - 1));
      if (cal_cnt_reg == 12'(dbsi_pkg::CAL_CYC - 1))
      begin
        cal_cnt_reg <= dbsi_pkg::CNT_RST;
      end
      else
      begin
        cal_cnt_reg <= cal_cnt_reg + 12'h001;
      end
    end
  end

  // Delay-loop lock: stable enabled cycles, restarted by a clock stop
  always_ff @(posedge k_clk)
  begin
    if (k_rst || lrst_s2_reg || !en_s2_reg)
    begin
      lock_cnt_reg <= dbsi_pkg::CNT_RST;
      locked_reg   <= 1'b0;
    end
    else if (lock_cnt_reg == 12'(dbsi_pkg::LOCK_CYC - 1))
    begin
      locked_reg <= 1'b1;
    end
    else
    begin
      lock_cnt_reg <= lock_cnt_reg + 12'h001;
    end
  end

  // Core side watches the rising-edge toggle; a long silence means a stop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      kt_s1_reg    <= 1'b0;
      kt_s2_reg    <= 1'b0;
      kt_s3_reg    <= 1'b0;
      idle_cnt_reg <= dbsi_pkg::IDLE_RST;
      lrst_reg     <= 1'b0;
    end
    else
    begin
      kt_s1_reg <= rise_tog_reg;
      kt_s2_reg <= kt_s1_reg;
      kt_s3_reg <= kt_s2_reg;
      if (kt_s2_reg != kt_s3_reg)
      begin
        idle_cnt_reg <= dbsi_pkg::IDLE_RST;
        lrst_reg     <= 1'b0;
      end
      else if (idle_cnt_reg == 4'(dbsi_pkg::STOP_CYC - 1))
      begin
        lrst_reg <= 1'b1;
      end
      else
      begin
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
      end
    end
  end

  // Checks on the link domain
  read_lat2_a: assert property (@(posedge k_clk) disable iff (k_rst)
    (rd_cmd && !lat1) ##1 (!lat1) [*2] |=>
      oe_rise_reg && q_hi_reg == $past(rd_data2_reg[35:18]))
    else $error("read data not driven two rises after command");

  read_lat1_a: assert property (@(posedge k_clk) disable iff (k_rst)
    (rd_cmd && lat1) ##1 lat1 |-> ##1 oe_rise_reg)
    else $error("fallback read not driven one rise after command");

  bus_release_a: assert property (@(posedge k_clk) disable iff (k_rst)
    (!rd_cmd) [*3] |=> !oe_rise_reg)
    else $error("data bus still driven with no read pending");

  write_addr_a: assert property (@(posedge k_clk) disable iff (k_rst)
    wr_cmd |=> wr_addr_reg == $past(addr) ##1 pd_addr_reg == $past(addr, 2))
    else $error("write address not captured");

  posted_write_a: assert property (@(posedge k_clk) disable iff (k_rst)
    pd_valid_reg |=> pw_valid_reg && pw_addr_reg == $past(pd_addr_reg))
    else $error("write burst not posted");

  lane_gate_a: assert property (@(posedge k_clk) disable iff (k_rst)
    wr_phase_reg |=> pd_m0_reg == ~$past(byte_lane_write_select_n))
    else $error("lane enables do not follow the selects");

  cal_period_a: assert property (@(posedge k_clk) disable iff (k_rst)
    cal_pulse_reg |-> cal_cnt_reg == 12'h000 ##1 !cal_pulse_reg)
    else $error("impedance update off its period");

  lock_time_a: assert property (@(posedge k_clk) disable iff (k_rst)
    $rose(locked_reg) |-> $past(lock_cnt_reg) == 12'h7ff)
    else $error("delay loop locked early");

  valid_lead_a: assert property (@(posedge k_clk) disable iff (k_rst)
    $rose(valid_reg) |-> !oe_rise_reg ##1 oe_rise_reg)
    else $error("valid flag not half a cycle ahead of data");

endmodule

/* File: verif/dbsi_ctrl_model.sv */
/*
  Behavioural memory controller for the burst SRAM link: commands,
  addresses, write bursts and lane selects, all timed on k_clk.
  Assumes the bench resolves the shared data wires from dq_drv_oe and dq_oe.
*/
`timescale 1ns/10ps
module dbsi_ctrl_model
(
  input  wire logic                      k_clk,
  output logic                           load_strobe_n,
  output logic                           read_write_sel,
  output logic [dbsi_pkg::ADDR_W-1:0]    addr,
  output logic [dbsi_pkg::WORD_W-1:0]    dq_drv,
  output logic [dbsi_pkg::LANES-1:0]     lanes_n,
  output logic                           dq_drv_oe
);
  logic [dbsi_pkg::LINE_W-1:0]  pend_d;   // Burst of the command on the pins
  logic [dbsi_pkg::LINE_LN-1:0] pend_l;   // Its lane selects, active low
  logic [dbsi_pkg::LINE_W-1:0]  take_d;   // Burst of the write taken last rise
  logic [dbsi_pkg::LINE_LN-1:0] take_l;
  logic                         take_wr;  // A write was taken at the last rise
  logic [dbsi_pkg::LINE_W-1:0]  cur_d;    // Burst now on the data wires
  logic [dbsi_pkg::LINE_LN-1:0] cur_l;

  // Power-up: deselected, data wires released
  initial
  begin
    load_strobe_n  = 1'b1;
    read_write_sel = 1'b0;
    addr           = dbsi_pkg::ADDR_RST;
    dq_drv         = dbsi_pkg::WORD_RST;
    lanes_n        = 2'h3;
    dq_drv_oe      = 1'b0;
    take_wr        = 1'b0;
  end

  // One command slot; entered just after a rise, left just after the next
  task automatic issue(input logic rw, input logic [dbsi_pkg::ADDR_W-1:0] a,
                       input logic [35:0] d, input logic [3:0] ln);
    load_strobe_n  = 1'b0;
    read_write_sel = rw;
    addr           = a;
    pend_d         = d;
    pend_l         = ln;
    @(posedge k_clk);
    #1;
  endtask

  // Idle slots; select and address may carry junk, which must be ignored
  task automatic idle(input int n, input logic rw, input logic [dbsi_pkg::ADDR_W-1:0] a);
    load_strobe_n  = 1'b1;
    read_write_sel = rw;
    addr           = a;
    repeat (n)
    begin
      @(posedge k_clk);
      #1;
    end
  endtask

  // Note the write the device takes at this rise
  always @(posedge k_clk)
  begin
    take_wr <= ~load_strobe_n & ~read_write_sel;
    take_d  <= pend_d;
    take_l  <= pend_l;
  end

  // Word0 goes out after the fall so it is settled at the next rise
  always @(negedge k_clk)
  begin
    #1;
    dq_drv_oe = take_wr;
    cur_d     = take_d;
    cur_l     = take_l;
    dq_drv    = take_d[17:0];
    lanes_n   = take_l[1:0];
  end

  // Word1 follows after the rise and stands until the fall samples it
  always @(posedge k_clk)
  begin
    #1;
    dq_drv  = cur_d[35:18];
    lanes_n = cur_l[3:2];
  end
endmodule

/* File: verif/tb_top.sv */
/*
  Self-checking bench for the burst SRAM device block: writes, reads in
  both latency modes, lane masks, posted write bypass, echo clocks, lock
  and impedance timing, link clock stop.
  Assumes dbsi_pkg and dbsi_ctrl_model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  logic        clk;            // Core clock, 4 ns
  logic        k_clk;          // Link clock, 32 ns, gated by k_run
  logic        k_run;
  logic        rst;
  logic        dl_dis_n;       // Delay-loop disable pin level
  logic        load_strobe_n;
  logic        read_write_sel;
  logic        dq_drv_oe;
  logic [20:0] addr;
  logic [17:0] dq_drv;
  logic [17:0] dq_out;
  logic [17:0] dq_bus;         // Resolved shared data wires
  logic [1:0]  lanes_n;
  logic        dq_oe;
  logic        echo_clock;
  logic        echo_clock_n;
  logic        output_valid_flag;
  logic        impedance_update;
  logic        delay_loop_locked;
  int          error_cnt;
  int          checks_done;

  // Nobody driving: a toggling pattern, so stale data never looks valid
  assign dq_bus = dq_oe ? dq_out : (dq_drv_oe ? dq_drv : {9{k_clk, ~k_clk}});

  dbsi_ctrl_model ctl (.k_clk(k_clk), .load_strobe_n(load_strobe_n),
    .read_write_sel(read_write_sel), .addr(addr), .dq_drv(dq_drv),
    .lanes_n(lanes_n), .dq_drv_oe(dq_drv_oe));

  dbsi_sram uut (.clk(clk), .rst(rst), .k_clk(k_clk), .load_strobe_n(load_strobe_n),
    .read_write_sel(read_write_sel), .addr(addr), .dq_in(dq_bus),
    .byte_lane_write_select_n(lanes_n), .delay_loop_disable_n(dl_dis_n),
    .dq_out(dq_out), .dq_oe(dq_oe), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n), .output_valid_flag(output_valid_flag),
    .impedance_update(impedance_update), .delay_loop_locked(delay_loop_locked));

  // Core clock
  always #2 clk = ~clk;

  // Link clock, offset so its edges never meet the core clock's
  initial
  begin
    #3.1;
    forever #16 if (k_run) k_clk = ~k_clk;
  end

  task automatic chkw(input string nm, input logic [35:0] e, input logic [35:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Stored line after a masked write; lanes run 0..3 from bit 0
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] ln);
    logic [35:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (!ln[i]) r[i*9 +: 9] = n[i*9 +: 9];
    return r;
  endfunction

  // Two back-to-back reads, checked half cycle by half cycle
  task automatic rd2(input logic [20:0] a0, input logic [20:0] a1,
                     input logic [35:0] e0, input logic [35:0] e1, input int lat);
    logic [35:0] e [2];
    int          k;
    e[0] = e0;
    e[1] = e1;
    ctl.issue(1'b1, a0, 36'h0, 4'hf);
    chkw("valid early", 36'h0, output_valid_flag);
    ctl.issue(1'b1, a1, 36'h0, 4'hf);
    ctl.idle(0, 1'b1, a1);
    for (int i = 2; i <= 5; i++)
    begin
      @(negedge k_clk);
      #8;
      k = i - 1 - lat;
      if (k >= 0 && k <= 1) chkw("word1", e[k][35:18], dq_bus);
      k = i - lat;
      chkw("valid", (k >= 0 && k <= 1), output_valid_flag);
      @(posedge k_clk);
      #8;
      if (k >= 0 && k <= 1) chkw("word0", e[k][17:0], dq_bus);
      chkw("drive", (k >= 0 && k <= 1), dq_oe);
    end
    @(posedge k_clk);
    #1;
  endtask

  // Runs 2060 link cycles: echo clocks, lock moment, impedance spacing
  task automatic lock_watch(input bit imp);
    int p0;
    int p1;
    p0 = -1;
    p1 = -1;
    for (int n = 1; n <= 2060; n++)
    begin
      @(posedge k_clk);
      #8;
      chkw("echo", 36'h2, {echo_clock, echo_clock_n});
      if (impedance_update === 1'b1 && p0 >= 0 && p1 < 0) p1 = n;
      if (impedance_update === 1'b1 && p0 < 0) p0 = n;
      if (n == 2040) chkw("lock early", 36'h0, delay_loop_locked);
    end
    chkw("lock", 36'h1, delay_loop_locked);
    if (imp) chkw("cal gap", 36'd1024, 36'(p1 - p0));
    // Back to the usual drive point just after a rise
    @(posedge k_clk);
    #1;
  endtask

  task automatic t_wr_rd();
    ctl.issue(1'b0, 21'h00011, 36'h123456789, 4'h0);
    ctl.issue(1'b0, 21'h00022, 36'habcdef012, 4'h0);
    rd2(21'h00011, 21'h00022, 36'h123456789, 36'habcdef012, 2);
    ctl.idle(2, 1'b1, 21'h0);
  endtask

  task automatic t_lanes();
    ctl.issue(1'b0, 21'h00033, 36'h111111111, 4'h0);
    ctl.issue(1'b0, 21'h00033, 36'h2aaaa5555, 4'h6);
    ctl.issue(1'b0, 21'h00044, 36'h0f0f0f0f0, 4'h0);
    rd2(21'h00033, 21'h00044, merge(36'h111111111, 36'h2aaaa5555, 4'h6),
        36'h0f0f0f0f0, 2);
    ctl.idle(2, 1'b1, 21'h0);
  endtask

  // Junk on the pins with the strobe high, then short-latency reads
  task automatic t_mode1();
    dl_dis_n = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      ctl.idle(1, 1'b0, 21'h00011);
      chkw("nop drive", 36'h0, dq_oe);
    end
    rd2(21'h00011, 21'h00022, 36'h123456789, 36'habcdef012, 1);
    dl_dis_n = 1'b1;
    ctl.idle(3, 1'b1, 21'h0);
  endtask

  // Link clock held low for 48 ns, longer than the 30 ns reset limit
  task automatic t_stop();
    @(negedge k_clk);
    k_run = 1'b0;
    #40;
    k_run = 1'b1;
    @(posedge k_clk);
    #1;
    lock_watch(1'b0);
  endtask

  // Watchdog, well beyond the two lock waits
  initial
  begin
    #300000;
    error_cnt++;
    summarize();
  end

  initial
  begin
    clk         = 1'b0;
    k_clk       = 1'b0;
    k_run       = 1'b1;
    rst         = 1'b1;
    dl_dis_n    = 1'b1;
    error_cnt   = 0;
    checks_done = 0;
    repeat (10) @(posedge k_clk);
    #1;
    chkw("reset drive", 36'h0, dq_oe);
    chkw("reset valid", 36'h0, output_valid_flag);
    rst = 1'b0;
    // Reset leaves the link domain two rises late; echo runs from then on
    repeat (2) @(posedge k_clk);
    lock_watch(1'b1);
    t_wr_rd();
    t_lanes();
    t_mode1();
    t_stop();
    summarize();
  end
endmodule
